// >>> logic/emps_params.svh
`ifndef EMPS_PARAMS_SVH
`define EMPS_PARAMS_SVH

`define EMPS_OFF_SIX     8'h00
`define EMPS_OFF_SEVEN   8'h04
`define EMPS_OFF_EIGHT   8'h08
`define EMPS_REG_RESET   32'h0000_0000
`define EMPS_FIELD_W     4
`define EMPS_SEL_IDLE    4'h0
`define EMPS_SEL_MEM     4'h1
`define EMPS_SEL_RTU_OUT 4'h4
`define EMPS_SEL_GPIO    4'h8
`define EMPS_STRB_ALL    4'hf
`define EMPS_RESP_OKAY   2'h0
`define EMPS_RESP_SLVERR 2'h2
`define EMPS_PAD_N       17
`define EMPS_RTU_N       4

`endif

// >>> logic/emps_pkg.sv
package emps_pkg;
`include "emps_params.svh"

  typedef enum logic [4:0] {
    EMPS_ROUTE_NONE    = 5'h01,
    EMPS_ROUTE_MEM     = 5'h02,
    EMPS_ROUTE_GPIO    = 5'h04,
    EMPS_ROUTE_RTU_IN  = 5'h08,
    EMPS_ROUTE_RTU_OUT = 5'h10
  } emps_route_t;

  // reserved codes fall through to none, so a bad setting never drives the pad
  function automatic emps_route_t emps_decode(input logic [3:0] code, input logic four);
    emps_route_t r;
    r = EMPS_ROUTE_NONE;
    if (code == `EMPS_SEL_MEM) begin
      r = EMPS_ROUTE_MEM;
    end else if (code == `EMPS_SEL_GPIO) begin
      r = EMPS_ROUTE_GPIO;
    end else if (four && code == `EMPS_SEL_IDLE) begin
      r = EMPS_ROUTE_RTU_IN;
    end else if (four && code == `EMPS_SEL_RTU_OUT) begin
      r = EMPS_ROUTE_RTU_OUT;
    end
    return r;
  endfunction

  function automatic logic [3:0] emps_field(input logic [31:0] r, input int unsigned idx);
    return r[idx*`EMPS_FIELD_W +: `EMPS_FIELD_W];
  endfunction

  function automatic logic [31:0] emps_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction

endpackage

// >>> logic/emps_pad_route.sv
`timescale 1ns/1ps
`include "emps_params.svh"
module emps_pad_route
  import emps_pkg::*;
#(
  parameter bit FOUR = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] sel,
  input  wire logic       mem_o,
  input  wire logic       mem_oe,
  input  wire logic       gpio_o,
  input  wire logic       gpio_oe,
  input  wire logic       rtu_o,
  input  wire logic       pad_i,
  output logic            pad_o,
  output logic            pad_oe,
  output logic            mem_i,
  output logic            gpio_i,
  output logic            rtu_i
);

  logic        sync1_r;
  logic        sync2_r;
  emps_route_t route;

  assign route = emps_decode(sel, FOUR);

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pad_i;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      unique case (route)
        EMPS_ROUTE_MEM: begin // RULE3
          pad_o  <= mem_o;
          pad_oe <= mem_oe;
        end
        EMPS_ROUTE_GPIO: begin // RULE4
          pad_o  <= gpio_o;
          pad_oe <= gpio_oe;
        end
        EMPS_ROUTE_RTU_OUT: begin // RULE5
          pad_o  <= rtu_o;
          pad_oe <= 1'b1;
        end
        EMPS_ROUTE_RTU_IN, EMPS_ROUTE_NONE: begin // RULE10
          pad_o  <= 1'b0;
          pad_oe <= 1'b0;
        end
      endcase
    end
  end

  // unselected functions see a quiet zero rather than the pad
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_i  <= 1'b0;
      gpio_i <= 1'b0;
      rtu_i  <= 1'b0;
    end else begin
      mem_i  <= (route == EMPS_ROUTE_MEM) && sync2_r;
      gpio_i <= (route == EMPS_ROUTE_GPIO) && sync2_r;
      rtu_i  <= (route == EMPS_ROUTE_RTU_IN) && sync2_r; // RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_idle_tristate;
    sel == `EMPS_SEL_IDLE |=> !pad_oe;
  endproperty
  a_idle_tristate: assert property (p_idle_tristate) else $error("idle code drove pad"); // RULE3

  property p_mem_drive;
    sel == `EMPS_SEL_MEM |=> pad_o == $past(mem_o) && pad_oe == $past(mem_oe);
  endproperty
  a_mem_drive: assert property (p_mem_drive) else $error("memory route wrong"); // RULE3

  property p_gpio_drive;
    sel == `EMPS_SEL_GPIO |=> pad_o == $past(gpio_o) && pad_oe == $past(gpio_oe);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio route wrong"); // RULE4

  property p_rtu_drive;
    FOUR && sel == `EMPS_SEL_RTU_OUT |=> pad_oe && pad_o == $past(rtu_o);
  endproperty
  a_rtu_drive: assert property (p_rtu_drive) else $error("rtu output route wrong"); // RULE5

  property p_reserved_quiet;
    // all four flops take the route of the same edge, so look one cycle on only
    route == EMPS_ROUTE_NONE |=> !pad_oe && !mem_i && !gpio_i && !rtu_i;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code active"); // RULE10

endmodule

// >>> logic/emps_top.sv
// How it works
// RULE1: each register holds eight 4-bit select fields, one per pad
// RULE2: fields read back last write and clear to zero on reset
// RULE3: two-function pad: code 0 tristates, code 1 routes memory signal
// RULE4: code 8 routes the io bit; codes 9 to f are reserved
// RULE5: four-function pad: 0 rtu input, 1 memory, 4 rtu output, 8 io
// RULE6: sixth register low fields: row strobe, clock enable, memory clock
// RULE7: seventh top field wait input; then read-not-write, oe, we, cs5
// RULE8: seventh register io bank three 9..15, chip selects 4, 3, 2
// RULE9: eighth register fields 31-28 to 11-8: data bits 8 to 13
// RULE10: reserved codes leave the pad tristated and route nothing
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "emps_params.svh"
module emps_top
  import emps_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET,
  input  wire logic [ADDR_W-1:0]       AWADDR,
  input  wire logic                    AWVALID,
  output logic                         AWREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output logic                         WREADY,
  output logic [1:0]                   BRESP,
  output logic                         BVALID,
  input  wire logic                    BREADY,
  input  wire logic [ADDR_W-1:0]       ARADDR,
  input  wire logic                    ARVALID,
  output logic                         ARREADY,
  output logic [31:0]                  RDATA,
  output logic [1:0]                   RRESP,
  output logic                         RVALID,
  input  wire logic                    RREADY,
  input  wire logic [`EMPS_PAD_N-1:0]  MEM_OUT,
  input  wire logic [`EMPS_PAD_N-1:0]  MEM_OE,
  output logic      [`EMPS_PAD_N-1:0]  MEM_IN,
  input  wire logic [`EMPS_PAD_N-1:0]  GPIO_OUT,
  input  wire logic [`EMPS_PAD_N-1:0]  GPIO_OE,
  output logic      [`EMPS_PAD_N-1:0]  GPIO_IN,
  input  wire logic [`EMPS_RTU_N-1:0]  RTU_OUT,
  output logic      [`EMPS_RTU_N-1:0]  RTU_IN,
  input  wire logic [`EMPS_PAD_N-1:0]  PAD_IN,
  output logic      [`EMPS_PAD_N-1:0]  PAD_OUT,
  output logic      [`EMPS_PAD_N-1:0]  PAD_OE
);

  //////////////////////////////////////////////////////////////////////////
  // register file and bus state

  logic [31:0]       reg_six_r;
  logic [31:0]       reg_seven_r;
  logic [31:0]       reg_eight_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              do_write;
  logic [`EMPS_PAD_N-1:0] rtu_in_w;

  assign AWREADY = awready_r;
  assign WREADY  = wready_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(`EMPS_OFF_SIX) || a == ADDR_W'(`EMPS_OFF_SEVEN) ||
           a == ADDR_W'(`EMPS_OFF_EIGHT);
  endfunction

  // both halves captured and no answer still pending
  assign do_write = !awready_r && !wready_r && !bvalid_r;

  //////////////////////////////////////////////////////////////////////////
  // write address and data: taken in either order, held until the answer

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      awready_r <= 1'b1;
      waddr_r   <= '0;
    end else if (AWVALID && awready_r) begin
      awready_r <= 1'b0;
      waddr_r   <= AWADDR;
    end else if (bvalid_r && BREADY) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wready_r <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (WVALID && wready_r) begin
      wready_r <= 1'b0;
      wdata_r  <= WDATA;
      wstrb_r  <= WSTRB;
    end else if (bvalid_r && BREADY) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `EMPS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(waddr_r) ? `EMPS_RESP_OKAY : `EMPS_RESP_SLVERR;
    end else if (bvalid_r && BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // select registers: all bits writable, byte strobes honoured

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      reg_six_r   <= `EMPS_REG_RESET; // RULE2
      reg_seven_r <= `EMPS_REG_RESET; // RULE2
      reg_eight_r <= `EMPS_REG_RESET; // RULE2
    end else if (do_write) begin
      if (waddr_r == ADDR_W'(`EMPS_OFF_SIX)) begin
        reg_six_r <= emps_merge(reg_six_r, wdata_r, wstrb_r); // RULE2
      end
      if (waddr_r == ADDR_W'(`EMPS_OFF_SEVEN)) begin
        reg_seven_r <= emps_merge(reg_seven_r, wdata_r, wstrb_r); // RULE2
      end
      if (waddr_r == ADDR_W'(`EMPS_OFF_EIGHT)) begin
        reg_eight_r <= emps_merge(reg_eight_r, wdata_r, wstrb_r); // RULE2
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel: one outstanding read, data latched with the address

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `EMPS_RESP_OKAY;
    end else if (ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= is_mapped(ARADDR) ? `EMPS_RESP_OKAY : `EMPS_RESP_SLVERR;
      if (ARADDR == ADDR_W'(`EMPS_OFF_SIX)) begin
        rdata_r <= reg_six_r; // RULE2
      end else if (ARADDR == ADDR_W'(`EMPS_OFF_SEVEN)) begin
        rdata_r <= reg_seven_r;
      end else if (ARADDR == ADDR_W'(`EMPS_OFF_EIGHT)) begin
        rdata_r <= reg_eight_r;
      end else begin
        rdata_r <= '0;
      end
    end else if (rvalid_r && RREADY) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pad map: pads 0-2 from the sixth register, 3-10 the seventh, 11-16 the
  // eighth; the upper sixth fields and the two lowest eighth fields are
  // stored only, their pads live outside this slice

  for (genvar p = 0; p < `EMPS_PAD_N; p++) begin : g_pad
    localparam int  FLD  = p < 3 ? 2 - p : (p < 11 ? 10 - p : 18 - p);
    localparam bit  FOUR = p <= 3;
    localparam int  RTU  = p < 3 ? p + 1 : 0;
    logic [3:0] sel;
    logic       rtu_o;

    if (p < 3) begin : g_six
      assign sel = emps_field(reg_six_r, FLD); // RULE1 RULE6
    end else if (p < 11) begin : g_seven
      assign sel = emps_field(reg_seven_r, FLD); // RULE1 RULE7 RULE8
    end else begin : g_eight
      assign sel = emps_field(reg_eight_r, FLD); // RULE1 RULE9
    end

    if (FOUR) begin : g_rtu
      assign rtu_o = RTU_OUT[RTU]; // RULE5
    end else begin : g_nortu
      assign rtu_o = 1'b0;
    end

    emps_pad_route #(
      .FOUR (FOUR)
    ) u_route (
      .clk     (CORE_CLK),
      .rst     (RESET),
      .sel     (sel),
      .mem_o   (MEM_OUT[p]),
      .mem_oe  (MEM_OE[p]),
      .gpio_o  (GPIO_OUT[p]),
      .gpio_oe (GPIO_OE[p]),
      .rtu_o   (rtu_o),
      .pad_i   (PAD_IN[p]),
      .pad_o   (PAD_OUT[p]),
      .pad_oe  (PAD_OE[p]),
      .mem_i   (MEM_IN[p]),
      .gpio_i  (GPIO_IN[p]),
      .rtu_i   (rtu_in_w[p])
    );
  end

  // rtu bit order: bit 0 on the wait pad, bits 1..3 on pads 0..2
  assign RTU_IN = {rtu_in_w[2], rtu_in_w[1], rtu_in_w[0], rtu_in_w[3]}; // RULE5

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  property p_reset_clear;
    $past(RESET) |-> reg_six_r == `EMPS_REG_RESET && reg_seven_r == `EMPS_REG_RESET &&
                     reg_eight_r == `EMPS_REG_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left a field set"); // RULE2

  property p_write_full;
    do_write && waddr_r == ADDR_W'(`EMPS_OFF_SEVEN) && wstrb_r == `EMPS_STRB_ALL
      |=> reg_seven_r == $past(wdata_r);
  endproperty
  a_write_full: assert property (p_write_full) else $error("write not stored"); // RULE2

  property p_read_back;
    ARVALID && ARREADY && ARADDR == ADDR_W'(`EMPS_OFF_EIGHT)
      |=> RVALID && RDATA == $past(reg_eight_r) && RRESP == `EMPS_RESP_OKAY;
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong"); // RULE2

  property p_write_answer;
    do_write |=> BVALID ##0 (BVALID && !AWREADY && !WREADY) [*1];
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

  property p_unmapped_read;
    ARVALID && ARREADY && !is_mapped(ARADDR) |=> RRESP == `EMPS_RESP_SLVERR && RDATA == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered ok");

  property p_six_map;
    g_pad[0].sel == reg_six_r[11:8] && g_pad[2].sel == reg_six_r[3:0];
  endproperty
  a_six_map: assert property (p_six_map) else $error("sixth field map wrong"); // RULE6

  property p_seven_map;
    g_pad[3].sel == reg_seven_r[31:28] && g_pad[7].sel == reg_seven_r[15:12] &&
    g_pad[10].sel == reg_seven_r[3:0];
  endproperty
  a_seven_map: assert property (p_seven_map) else $error("seventh field map wrong"); // RULE7

  property p_eight_map;
    g_pad[11].sel == reg_eight_r[31:28] && g_pad[16].sel == reg_eight_r[11:8];
  endproperty
  a_eight_map: assert property (p_eight_map) else $error("eighth field map wrong"); // RULE9

  property p_cs_gpio;
    reg_seven_r[11:8] == `EMPS_SEL_GPIO |=> PAD_OUT[8] == $past(GPIO_OUT[8]);
  endproperty
  a_cs_gpio: assert property (p_cs_gpio) else $error("chip select pad io wrong"); // RULE8

  property p_wait_rtu_in;
    reg_seven_r[31:28] == `EMPS_SEL_IDLE ##1 reg_seven_r[31:28] == `EMPS_SEL_IDLE [*3]
      |-> RTU_IN[0] == $past(PAD_IN[3], 3) && !PAD_OE[3];
  endproperty
  a_wait_rtu_in: assert property (p_wait_rtu_in) else $error("rtu input route wrong"); // RULE5

endmodule

// >>> bench/emps_pad_model.sv
`timescale 1ns/1ps
`include "emps_params.svh"
module emps_pad_model (
  input  wire logic [`EMPS_PAD_N-1:0] pad_out,
  input  wire logic [`EMPS_PAD_N-1:0] pad_oe,
  input  wire logic [`EMPS_PAD_N-1:0] ext_lvl,
  output logic      [`EMPS_PAD_N-1:0] pad_in
);
  // a released pad shows the board driver, never the last level the block drove
  always_comb begin
    for (int i = 0; i < `EMPS_PAD_N; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_lvl[i];
    end
  end
endmodule

// >>> bench/ext_mem_pad_function_select_bench.sv
`timescale 1ns/1ps
`include "emps_params.svh"
module ext_mem_pad_function_select_bench;
  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [16:0] mem_out, mem_oe, mem_in, gpio_out, gpio_oe, gpio_in;
  logic [16:0] pad_in, pad_out, pad_oe, ext;
  logic [3:0]  rtu_out, rtu_in;
  logic [31:0] seed = 32'h0001_6d4c;
  logic [31:0] regs [3];
  int          error_cnt = 0;
  int          n_compared = 0;

  emps_top #(.ADDR_W(8)) DUT (
    .CORE_CLK(clk), .RESET(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .MEM_OUT(mem_out), .MEM_OE(mem_oe), .MEM_IN(mem_in), .GPIO_OUT(gpio_out),
    .GPIO_OE(gpio_oe), .GPIO_IN(gpio_in), .RTU_OUT(rtu_out), .RTU_IN(rtu_in),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe)
  );
  emps_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [16:0] rnd17();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[16:0];
  endfunction

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    check(32'(bresp), 32'(er), "write response");
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    check(rdata, ed, "read data");
    check(32'(rresp), 32'(er), "read response");
  endtask

  task automatic readback();
    for (int i = 0; i < 3; i++) axi_read(8'(i * 4), regs[i], `EMPS_RESP_OKAY);
  endtask

  task automatic program_regs(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    regs[0] = a;
    regs[1] = b;
    regs[2] = c;
    for (int i = 0; i < 3; i++) axi_write(8'(i * 4), regs[i], `EMPS_STRB_ALL, `EMPS_RESP_OKAY);
  endtask

  // fresh peripheral and board levels, then enough edges for the pad input synchronisers
  task automatic settle_check();
    logic [3:0] c, rexp;
    logic       eoe, eo, lvl;
    int         ri;
    @(posedge clk);
    mem_out <= rnd17();
    mem_oe <= rnd17();
    gpio_out <= rnd17();
    gpio_oe <= rnd17();
    rtu_out <= 4'(rnd17());
    ext <= rnd17();
    repeat (5) @(posedge clk);
    @(negedge clk);
    rexp = 4'h0;
    for (int p = 0; p < 17; p++) begin
      c = p < 3 ? regs[0][(2-p)*4 +: 4] : p < 11 ? regs[1][(10-p)*4 +: 4] : regs[2][(18-p)*4 +: 4];
      ri = (p == 3) ? 0 : p + 1;
      eoe = 1'b0;
      eo = 1'b0;
      if (c == `EMPS_SEL_MEM) begin
        eoe = mem_oe[p];
        eo = mem_out[p];
      end else if (c == `EMPS_SEL_GPIO) begin
        eoe = gpio_oe[p];
        eo = gpio_out[p];
      end else if (p < 4 && c == `EMPS_SEL_RTU_OUT) begin
        eoe = 1'b1;
        eo = rtu_out[ri];
      end
      lvl = eoe ? eo : ext[p];
      if (p < 4 && c == `EMPS_SEL_IDLE) rexp[ri] = lvl;
      check(32'(pad_oe[p]), 32'(eoe), "pad enable");
      if (eoe) check(32'(pad_out[p]), 32'(eo), "pad level");
      check(32'(mem_in[p]), 32'(c == `EMPS_SEL_MEM ? lvl : 1'b0), "memory in");
      check(32'(gpio_in[p]), 32'(c == `EMPS_SEL_GPIO ? lvl : 1'b0), "io in");
    end
    check(32'(rtu_in), 32'(rexp), "realtime in");
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    {mem_out, mem_oe, gpio_out, gpio_oe, ext} = '0;
    rtu_out = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    regs = '{32'h0, 32'h0, 32'h0};
    readback();
    axi_read(8'h0c, 32'h0, `EMPS_RESP_SLVERR);
    axi_write(8'h0c, 32'h1111_1111, `EMPS_STRB_ALL, `EMPS_RESP_SLVERR);
    readback();
    // every code on every field, reserved ones included
    for (int c = 0; c < 16; c++) begin
      program_regs({8{4'(c)}}, {8{4'(c)}}, {8{4'(c)}});
      settle_check();
      readback();
    end
    // one byte lane only: the other fields must keep their codes
    program_regs(32'h1111_1111, 32'h8888_8888, 32'h4444_4444);
    axi_write(8'h00, 32'hffff_ffff, 4'h2, `EMPS_RESP_OKAY);
    regs[0] = 32'h1111_ff11;
    readback();
    for (int k = 0; k < 20; k++) begin
      program_regs({rnd17(), 15'(rnd17())}, {rnd17(), 15'(rnd17())},
                   {rnd17(), 15'(rnd17())});
      settle_check();
      readback();
    end
    // reset in mid-run must clear every field again
    program_regs(32'h1818_4181, 32'h4811_8818, 32'h1881_8118);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    regs = '{32'h0, 32'h0, 32'h0};
    readback();
    settle_check();
    report_and_stop();
  end
endmodule
